// *** rtl/ubes_regs.svh ***
// Register map, field positions, reset values and counts of the serial port.
// Included by the design files; defines only.
`ifndef UBES_REGS_SVH
`define UBES_REGS_SVH

`define UBES_ADDR_W        16
`define UBES_ADDR_MODE     16'hff70
`define UBES_ADDR_ERR      16'hff71
`define UBES_ADDR_CSM      16'hff72
`define UBES_ADDR_BRG      16'hff73
`define UBES_ADDR_DATA     16'hff74
`define UBES_ADDR_STATE    16'hff75

`define UBES_RST_MODE      8'h00
`define UBES_RST_ERR       8'h00
`define UBES_RST_CSM       8'h00
`define UBES_RST_BRG       8'h00

`define UBES_MASK_MODE     8'hfc
`define UBES_MASK_CSM      8'h86
`define UBES_MASK_BRG      8'hf0

`define UBES_MODE_TXE      7
`define UBES_MODE_RXE      6
`define UBES_MODE_PS_HI    5
`define UBES_MODE_PS_LO    4
`define UBES_MODE_CL       3
`define UBES_MODE_SL       2

`define UBES_CSM_CSIE      7
`define UBES_CSM_DIR       2
`define UBES_CSM_CSCK      1

`define UBES_ERR_PE        2
`define UBES_ERR_FE        1
`define UBES_ERR_OVE       0

`define UBES_BRG_SRC_HI    7
`define UBES_BRG_SRC_LO    4
`define UBES_BRG_EXT       4'h8
`define UBES_BRG_INT_LAST  4'h7

`define UBES_PS_NONE       2'b00
`define UBES_PS_ZERO       2'b01
`define UBES_PS_ODD        2'b10
`define UBES_PS_EVEN       2'b11

`define UBES_OVS_MID       4'h7
`define UBES_OVS_LAST      4'hf
`define UBES_BITS_7        3'h6
`define UBES_BITS_8        3'h7

`endif

// *** rtl/ubes_pkg.sv ***
// Types shared by the serial port modules.
// Assumes ubes_regs.svh supplies the numbers.
package ubes_pkg;

  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP   = 3'b100
  } ubes_rx_e;

  typedef enum logic [2:0] {
    TX_IDLE   = 3'b000,
    TX_START  = 3'b001,
    TX_DATA   = 3'b010,
    TX_PARITY = 3'b011,
    TX_STOP1  = 3'b100,
    TX_STOP2  = 3'b101
  } ubes_tx_e;

  typedef logic [3:0] ubes_src_t;

endpackage : ubes_pkg

// *** rtl/ubes_baud_if.sv ***
// Link between the register side and the baud generator.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
`default_nettype none

interface ubes_baud_if;
  ubes_pkg::ubes_src_t src;
  logic                restart;
  logic                ext_pin;
  logic                ext_ok;
  logic                sck_int;
  logic                tick16;
  logic                sck;

  modport gen  (input src, restart, ext_pin, ext_ok, sck_int,
                output tick16, sck);
  modport user (output src, restart, ext_pin, ext_ok, sck_int,
                input tick16, sck);
endinterface : ubes_baud_if

`default_nettype wire

// *** rtl/ubes_baud_gen.sv ***
// Baud generator: system clock by 2^(n+1) prescaler or external pin edges.
// Assumes the external pin is already synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "ubes_regs.svh"

module ubes_baud_gen #(
  parameter int PRE_W = 8
) (
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  ubes_baud_if.gen   bif
);

  logic [PRE_W-1:0] cnt_q;
  logic [PRE_W-1:0] mask;
  logic             pin_q;
  logic             int_sel;
  logic             ext_sel;
  logic             pre_done;

  // Mask covers bits 0..code, so a wrap happens every 2^(code+1) cycles
  genvar gi;
  generate
    for (gi = 0; gi < PRE_W; gi++) begin : g_mask
      assign mask[gi] = (gi <= int'(bif.src));
    end
  endgenerate

  assign int_sel  = (bif.src <= `UBES_BRG_INT_LAST);
  assign ext_sel  = (bif.src == `UBES_BRG_EXT) && bif.ext_ok;
  assign pre_done = int_sel && ((cnt_q & mask) == mask);

  // A control write restarts the count; writes mid-frame corrupt timing
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else if (bif.restart || !int_sel) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= bif.ext_pin;
    end
  end

  // Oversample tick at 16x baud: fx/2^(n+1) internally, every pin rise outside
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bif.tick16 <= 1'b0;
    end else begin
      bif.tick16 <= pre_done || (ext_sel && bif.ext_pin && !pin_q);
    end
  end

  // Shift clock toggles per prescale wrap, giving fx/2^(n+2)
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bif.sck <= 1'b1;
    end else if (!bif.sck_int) begin
      bif.sck <= 1'b1;
    end else if (pre_done) begin
      bif.sck <= !bif.sck;
    end
  end

endmodule : ubes_baud_gen

`default_nettype wire

// *** rtl/uart_baud_and_error_status.sv ***
// Serial port: mode registers, UART frame engine, error status, baud source.
// Assumes a plain register port with read data one cycle after the strobe,
// and serial pins synchronous to I_CLK_SYS.
//
// How it works
// - Async needs clocked bits zero, LSB first
// - Unused pins released for port use
// - Error status defined only in async mode
// - Reset clears error status; bits 7-3 zero
// - Bit 2 set on parity mismatch
// - Bit 1 set on missing stop bit
// - Receiver checks one stop bit only
// - Bit 0 set on unread buffer overrun
// - Source field picks fx/2^(n+1) or pin
// - External baud pin only in async mode
// - Internal async rate fx/2^(n+1)/16
// - External async rate pin/16
// - Shift clock fx/2^(n+2)
// - Reset clears control; low nibble zero
// - Parity field: none, zero, odd, even
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ubes_regs.svh"

module uart_baud_and_error_status #(
  parameter int DATA_W = 8
) (
  input  wire logic                    I_CLK_SYS,
  input  wire logic                    I_RST,
  input  wire logic [`UBES_ADDR_W-1:0] i_ADDR,
  input  wire logic [DATA_W-1:0]       i_WDATA,
  input  wire logic                    i_WR,
  input  wire logic                    i_RD,
  output logic      [DATA_W-1:0]       o_RDATA,
  input  wire logic                    i_RXD,
  output logic                         o_TXD,
  input  wire logic                    i_ASCK,
  input  wire logic                    i_SCK,
  output logic                         o_SCK,
  output logic                         o_SCK_OE_N,
  output logic                         o_RXD_PORT,
  output logic                         o_TXD_PORT,
  output logic                         o_ASCK_PORT
);

  logic [DATA_W-1:0] mode_q;
  logic [DATA_W-1:0] csm_q;
  logic [DATA_W-1:0] brg_q;
  logic [2:0]        err_q;
  logic [DATA_W-1:0] rxbuf_q;
  logic              rx_full_q;

  logic wr_mode;
  logic wr_csm;
  logic wr_brg;
  logic wr_data;
  logic rd_err;
  logic rd_data;

  logic       txe;
  logic       rxe;
  logic [1:0] par_mode;
  logic       len8;
  logic       two_stop;
  logic       async_ok;
  logic       csi_on;
  logic       csi_int;
  logic       ext_src;

  ubes_baud_if bif ();

  assign wr_mode = i_WR && (i_ADDR == `UBES_ADDR_MODE);
  assign wr_csm  = i_WR && (i_ADDR == `UBES_ADDR_CSM);
  assign wr_brg  = i_WR && (i_ADDR == `UBES_ADDR_BRG);
  assign wr_data = i_WR && (i_ADDR == `UBES_ADDR_DATA);
  assign rd_err  = i_RD && (i_ADDR == `UBES_ADDR_ERR);
  assign rd_data = i_RD && (i_ADDR == `UBES_ADDR_DATA);

  assign txe      = mode_q[`UBES_MODE_TXE];
  assign rxe      = mode_q[`UBES_MODE_RXE];
  assign par_mode = mode_q[`UBES_MODE_PS_HI:`UBES_MODE_PS_LO];
  assign len8     = mode_q[`UBES_MODE_CL];
  assign two_stop = mode_q[`UBES_MODE_SL];
  assign csi_on   = csm_q[`UBES_CSM_CSIE];
  assign csi_int  = csi_on && csm_q[`UBES_CSM_CSCK];
  assign ext_src  = (brg_q[`UBES_BRG_SRC_HI:`UBES_BRG_SRC_LO]
                     == `UBES_BRG_EXT);

  // Any clocked-serial bit set makes the UART combination prohibited
  assign async_ok = (csm_q == `UBES_RST_CSM) && (txe || rxe);

  // Register writes; fixed-zero bits are masked off
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      mode_q <= `UBES_RST_MODE;
      csm_q  <= `UBES_RST_CSM;
      brg_q  <= `UBES_RST_BRG;
    end else begin
      if (wr_mode) begin
        mode_q <= i_WDATA & `UBES_MASK_MODE;
      end
      if (wr_csm) begin
        csm_q <= i_WDATA & `UBES_MASK_CSM;
      end
      if (wr_brg) begin
        brg_q <= i_WDATA & `UBES_MASK_BRG;
      end
    end
  end

  assign bif.src     = brg_q[`UBES_BRG_SRC_HI:`UBES_BRG_SRC_LO];
  assign bif.restart = wr_brg;
  assign bif.ext_pin = i_ASCK;
  assign bif.ext_ok  = async_ok;
  assign bif.sck_int = csi_int;

  ubes_baud_gen #(
    .PRE_W (8)
  ) u_baud (
    .i_clk (I_CLK_SYS),
    .i_rst (I_RST),
    .bif   (bif)
  );

  // Receiver
  ubes_pkg::ubes_rx_e rx_st_q;
  logic [3:0]         rx_ph_q;
  logic [2:0]         rx_bit_q;
  logic [7:0]         rx_sh_q;
  logic               rx_par_q;
  logic               rx_on;
  logic               rx_mid;
  logic               rx_last_bit;
  logic               rx_ones;
  logic               par_bad;
  logic               rx_done;
  logic               stop_bad;

  assign rx_on       = async_ok && rxe;
  assign rx_mid      = bif.tick16 && (rx_ph_q == `UBES_OVS_LAST);
  assign rx_last_bit = (rx_bit_q == (len8 ? `UBES_BITS_8 : `UBES_BITS_7));
  assign rx_ones     = ^rx_sh_q;
  // Odd: data plus parity holds an odd count of ones; zero mode never checks
  assign par_bad = ((par_mode == `UBES_PS_ODD)  && !(rx_ones ^ rx_par_q)) ||
                   ((par_mode == `UBES_PS_EVEN) &&  (rx_ones ^ rx_par_q));
  // Only the first stop bit is sampled; a second one is treated as idle
  assign rx_done  = (rx_st_q == ubes_pkg::RX_STOP) && rx_mid;
  assign stop_bad = !i_RXD;

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      rx_st_q  <= ubes_pkg::RX_IDLE;
      rx_ph_q  <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q  <= 8'h00;
      rx_par_q <= 1'b0;
    end else if (!rx_on) begin
      rx_st_q <= ubes_pkg::RX_IDLE;
    end else if (bif.tick16) begin
      rx_ph_q <= rx_ph_q + 4'h1;
      case (rx_st_q)
        ubes_pkg::RX_IDLE: begin
          if (!i_RXD) begin
            rx_st_q <= ubes_pkg::RX_START;
            rx_ph_q <= 4'h0;
          end
        end
        ubes_pkg::RX_START: begin
          // Re-align to mid-bit; a glitch shorter than half a bit is dropped
          if (rx_ph_q == `UBES_OVS_MID) begin
            rx_ph_q  <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_sh_q  <= 8'h00;
            rx_st_q  <= i_RXD ? ubes_pkg::RX_IDLE : ubes_pkg::RX_DATA;
          end
        end
        ubes_pkg::RX_DATA: begin
          if (rx_ph_q == `UBES_OVS_LAST) begin
            // LSB arrives first; 7-bit characters land in bits 6..0
            if (len8) begin
              rx_sh_q <= {i_RXD, rx_sh_q[7:1]};
            end else begin
              rx_sh_q <= {1'b0, i_RXD, rx_sh_q[6:1]};
            end
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_last_bit) begin
              rx_st_q <= (par_mode == `UBES_PS_NONE) ?
                         ubes_pkg::RX_STOP : ubes_pkg::RX_PARITY;
            end
          end
        end
        ubes_pkg::RX_PARITY: begin
          if (rx_ph_q == `UBES_OVS_LAST) begin
            rx_par_q <= i_RXD;
            rx_st_q  <= ubes_pkg::RX_STOP;
          end
        end
        ubes_pkg::RX_STOP: begin
          if (rx_ph_q == `UBES_OVS_LAST) begin
            rx_st_q <= ubes_pkg::RX_IDLE;
          end
        end
        default: begin
          rx_st_q <= ubes_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Receive buffer; a completed frame always overwrites it
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      rxbuf_q   <= 8'h00;
      rx_full_q <= 1'b0;
    end else if (rx_done) begin
      rxbuf_q   <= rx_sh_q;
      rx_full_q <= 1'b1;
    end else if (rd_data) begin
      rx_full_q <= 1'b0;
    end
  end

  // Error flags: set wins over the clear-on-read of the status register.
  // Until the buffer is read every new frame reports an overrun again.
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      err_q <= 3'h0;
    end else if (rx_done) begin
      err_q[`UBES_ERR_PE]  <= par_bad || (err_q[`UBES_ERR_PE] && !rd_err);
      err_q[`UBES_ERR_FE]  <= stop_bad || (err_q[`UBES_ERR_FE] && !rd_err);
      err_q[`UBES_ERR_OVE] <= rx_full_q ||
                              (err_q[`UBES_ERR_OVE] && !rd_err);
    end else if (rd_err) begin
      err_q <= 3'h0;
    end
  end

  // Transmitter
  ubes_pkg::ubes_tx_e tx_st_q;
  logic [3:0]         tx_ph_q;
  logic [2:0]         tx_bit_q;
  logic [7:0]         tx_sh_q;
  logic               tx_par_q;
  logic               tx_on;
  logic               tx_bit_end;
  logic               tx_last_bit;

  assign tx_on       = async_ok && txe;
  assign tx_bit_end  = bif.tick16 && (tx_ph_q == `UBES_OVS_LAST);
  assign tx_last_bit = (tx_bit_q == (len8 ? `UBES_BITS_8 : `UBES_BITS_7));

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      tx_st_q  <= ubes_pkg::TX_IDLE;
      tx_ph_q  <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_sh_q  <= 8'h00;
      tx_par_q <= 1'b0;
      o_TXD    <= 1'b1;
    end else if (!tx_on) begin
      tx_st_q <= ubes_pkg::TX_IDLE;
      o_TXD   <= 1'b1;
    end else begin
      if (bif.tick16) begin
        tx_ph_q <= tx_ph_q + 4'h1;
      end
      case (tx_st_q)
        ubes_pkg::TX_IDLE: begin
          o_TXD <= 1'b1;
          // A write while busy is ignored
          if (wr_data) begin
            tx_sh_q  <= len8 ? i_WDATA : {1'b0, i_WDATA[6:0]};
            tx_par_q <= (par_mode == `UBES_PS_ODD) ?
                        !(len8 ? ^i_WDATA : ^i_WDATA[6:0]) :
                        (par_mode == `UBES_PS_EVEN) ?
                        (len8 ? ^i_WDATA : ^i_WDATA[6:0]) : 1'b0;
            tx_ph_q  <= 4'h0;
            tx_bit_q <= 3'h0;
            tx_st_q  <= ubes_pkg::TX_START;
            o_TXD    <= 1'b0;
          end
        end
        ubes_pkg::TX_START: begin
          if (tx_bit_end) begin
            o_TXD   <= tx_sh_q[0];
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            tx_st_q <= ubes_pkg::TX_DATA;
          end
        end
        ubes_pkg::TX_DATA: begin
          if (tx_bit_end) begin
            tx_bit_q <= tx_bit_q + 3'h1;
            if (tx_last_bit) begin
              if (par_mode == `UBES_PS_NONE) begin
                o_TXD   <= 1'b1;
                tx_st_q <= ubes_pkg::TX_STOP1;
              end else begin
                o_TXD   <= tx_par_q;
                tx_st_q <= ubes_pkg::TX_PARITY;
              end
            end else begin
              o_TXD   <= tx_sh_q[0];
              tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            end
          end
        end
        ubes_pkg::TX_PARITY: begin
          if (tx_bit_end) begin
            o_TXD   <= 1'b1;
            tx_st_q <= ubes_pkg::TX_STOP1;
          end
        end
        ubes_pkg::TX_STOP1: begin
          if (tx_bit_end) begin
            tx_st_q <= two_stop ? ubes_pkg::TX_STOP2 : ubes_pkg::TX_IDLE;
          end
        end
        ubes_pkg::TX_STOP2: begin
          if (tx_bit_end) begin
            tx_st_q <= ubes_pkg::TX_IDLE;
          end
        end
        default: begin
          tx_st_q <= ubes_pkg::TX_IDLE;
          o_TXD   <= 1'b1;
        end
      endcase
    end
  end

  // Pin roles: a pin not needed by the chosen direction or source is a port
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      o_RXD_PORT  <= 1'b1;
      o_TXD_PORT  <= 1'b1;
      o_ASCK_PORT <= 1'b1;
      o_SCK_OE_N  <= 1'b1;
      o_SCK       <= 1'b1;
    end else begin
      o_RXD_PORT  <= !(async_ok && rxe) && !csi_on;
      o_TXD_PORT  <= !(async_ok && txe) && !csi_on;
      o_ASCK_PORT <= !(async_ok && ext_src) && !csi_on;
      // The shift pin is driven only with the internal clock selected
      o_SCK_OE_N  <= !csi_int;
      o_SCK       <= bif.sck;
    end
  end

  // Read port; unmapped addresses read zero
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      o_RDATA <= '0;
    end else if (i_RD) begin
      case (i_ADDR)
        `UBES_ADDR_MODE:  o_RDATA <= mode_q;
        // Undefined in clocked mode; reads zero there for determinism
        `UBES_ADDR_ERR:   o_RDATA <= csi_on ? 8'h00 :
                                     {5'h00, err_q};
        `UBES_ADDR_CSM:   o_RDATA <= csm_q;
        `UBES_ADDR_BRG:   o_RDATA <= brg_q;
        `UBES_ADDR_DATA:  o_RDATA <= rxbuf_q;
        `UBES_ADDR_STATE: o_RDATA <= {5'h00, async_ok, rx_full_q,
                                      (tx_st_q != ubes_pkg::TX_IDLE)};
        default:          o_RDATA <= 8'h00;
      endcase
    end
  end

  // External shift clock input is consumed by the clocked engine, not here
  logic unused_sck;
  assign unused_sck = i_SCK & csm_q[`UBES_CSM_DIR];

endmodule : uart_baud_and_error_status

`default_nettype wire

// *** bench/ubes_monitor.sv ***
// Concurrent checks on the serial port's register and pin behaviour.
// Bound to the top module; sees its ports only, one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "ubes_regs.svh"

module ubes_monitor #(
  parameter int DATA_W = 8
) (
  input wire logic                    I_CLK_SYS,
  input wire logic                    I_RST,
  input wire logic [`UBES_ADDR_W-1:0] i_ADDR,
  input wire logic [DATA_W-1:0]       i_WDATA,
  input wire logic                    i_WR,
  input wire logic                    i_RD,
  input wire logic [DATA_W-1:0]       o_RDATA,
  input wire logic                    o_TXD,
  input wire logic                    o_SCK_OE_N,
  input wire logic                    o_RXD_PORT,
  input wire logic                    o_TXD_PORT,
  input wire logic                    o_ASCK_PORT
);
  logic [7:0] mode_q;
  logic [7:0] csm_q;
  logic [7:0] brg_q;
  logic [9:0] idle_q;
  logic       legal;

  assign legal = (csm_q == 8'h00) && (mode_q[7] || mode_q[6]);

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      mode_q <= `UBES_RST_MODE;
      csm_q  <= `UBES_RST_CSM;
      brg_q  <= `UBES_RST_BRG;
    end else if (i_WR) begin
      if (i_ADDR == `UBES_ADDR_MODE) mode_q <= i_WDATA[7:0] & `UBES_MASK_MODE;
      if (i_ADDR == `UBES_ADDR_CSM) csm_q <= i_WDATA[7:0] & `UBES_MASK_CSM;
      if (i_ADDR == `UBES_ADDR_BRG) brg_q <= i_WDATA[7:0] & `UBES_MASK_BRG;
    end
  end

  // Saturating idle count; only a long-idle line proves the sender is free
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) idle_q <= 10'h000;
    else if (!o_TXD) idle_q <= 10'h000;
    else if (idle_q != 10'h3ff) idle_q <= idle_q + 10'h001;
  end

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  err_high_zero_a: assert property (i_RD && i_ADDR == `UBES_ADDR_ERR
    |=> o_RDATA[7:3] == 5'h00) else $error("status high bits set");
  err_clocked_a: assert property (i_RD && i_ADDR == `UBES_ADDR_ERR
    && csm_q[7] |=> o_RDATA == 8'h00) else $error("status in clocked mode");
  brg_read_a: assert property (i_RD && i_ADDR == `UBES_ADDR_BRG
    |=> o_RDATA == brg_q) else $error("baud control readback");
  rx_pin_free_a: assert property ((legal && mode_q[7:6] == 2'b10)[*2]
    |-> o_RXD_PORT) else $error("receive pin held in send-only mode");
  tx_pin_free_a: assert property ((legal && mode_q[7:6] == 2'b01)[*2]
    |-> o_TXD_PORT) else $error("send pin held in receive-only mode");
  rx_pin_used_a: assert property ((legal && mode_q[6])[*2]
    |-> !o_RXD_PORT) else $error("receive pin not taken");
  ext_pin_used_a: assert property ((legal && brg_q == 8'h80)[*2]
    |-> !o_ASCK_PORT) else $error("baud pin not taken");
  ext_pin_free_a: assert property ((brg_q[7:4] <= 4'h7 && !csm_q[7])
    [*2] |-> o_ASCK_PORT) else $error("baud pin held on internal source");
  shift_oe_a: assert property (!o_SCK_OE_N
    |-> $past(csm_q[7] && csm_q[1])) else $error("shift clock enabled");
  tx_start_a: assert property (i_WR && i_ADDR == `UBES_ADDR_DATA && legal
    && mode_q[7] && brg_q == 8'h20 && idle_q == 10'h3ff |-> ##[1:2] !o_TXD)
    else $error("start bit missing");

  cover property (i_RD && i_ADDR == `UBES_ADDR_ERR ##1 o_RDATA[2]);
  cover property (i_RD && i_ADDR == `UBES_ADDR_ERR ##1 o_RDATA[1]);
  cover property (i_RD && i_ADDR == `UBES_ADDR_ERR ##1 o_RDATA[0]);
  cover property ($fell(o_TXD));
endmodule // ubes_monitor

bind uart_baud_and_error_status ubes_monitor #(.DATA_W(DATA_W))
  ubes_monitor_inst (.I_CLK_SYS, .I_RST, .i_ADDR, .i_WDATA, .i_WR, .i_RD,
  .o_RDATA, .o_TXD, .o_SCK_OE_N, .o_RXD_PORT, .o_TXD_PORT, .o_ASCK_PORT);

`default_nettype wire

// *** bench/ubes_remote.sv ***
// Remote serial station: sends frames to the port and decodes its output.
// Assumes callers sit on or just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module ubes_remote (
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_line
);
  initial o_line = 1'b1;

  task automatic put_bit(input logic v, input int bc);
    o_line <= v;
    repeat (bc) @(posedge i_clk);
  endtask

  // Parity or stop level spoilt only when a scenario asks for it
  task automatic send(input logic [7:0] d, input int nb, input logic [1:0] ps,
                      input bit badp, input bit badst, input int bc);
    logic p;
    p = ^(d & ((nb == 8) ? 8'hff : 8'h7f));
    if (ps == 2'b10) p = ~p;
    if (ps == 2'b01) p = 1'b0;
    p = p ^ badp;
    put_bit(1'b0, bc);
    for (int i = 0; i < nb; i++) put_bit(d[i], bc);
    if (ps != 2'b00) put_bit(p, bc);
    put_bit(~badst, bc);
    // A spoilt stop is followed by one idle bit, so no false start is seen
    if (badst) put_bit(1'b1, bc);
  endtask

  // Mid-bit sampling; a wrong rate garbles the byte
  task automatic recv(output logic [7:0] d, output logic p, input int nb,
                      input int bc);
    int n;
    d = 8'h00;
    n = 0;
    while (i_line !== 1'b0 && n < 4000) begin
      @(posedge i_clk);
      n++;
    end
    repeat (bc / 2) @(posedge i_clk);
    for (int i = 0; i < nb; i++) begin
      repeat (bc) @(posedge i_clk);
      d[i] = i_line;
    end
    repeat (bc) @(posedge i_clk);
    p = i_line;
  endtask
endmodule // ubes_remote

`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the serial port: registers, receive errors,
// transmit framing and baud sources. Needs the remote station model.
`timescale 1ns/1ps
`default_nettype none
`include "ubes_regs.svh"

module tb_top;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        asck = 1'b0;
  logic        asck_run = 1'b0;
  int          asck_div = 0;
  logic [7:0]  rdata;
  logic        txd, rxd, sck, sck_oe_n, rxd_port, txd_port, asck_port;
  int          fail_count = 0;
  int          n_checks = 0;

  always #2.5 clk_sys = ~clk_sys;

  // External baud pin: one rising edge every 6 clocks
  always @(posedge clk_sys) begin
    if (asck_run) begin
      asck_div <= (asck_div + 1) % 3;
      if (asck_div == 2) asck <= ~asck;
    end
  end

  uart_baud_and_error_status uart_baud_and_error_status_inst (
    .I_CLK_SYS(clk_sys), .I_RST(rst), .i_ADDR(addr), .i_WDATA(wdata),
    .i_WR(wr), .i_RD(rd), .o_RDATA(rdata), .i_RXD(rxd), .o_TXD(txd),
    .i_ASCK(asck), .i_SCK(1'b1), .o_SCK(sck), .o_SCK_OE_N(sck_oe_n),
    .o_RXD_PORT(rxd_port), .o_TXD_PORT(txd_port), .o_ASCK_PORT(asck_port));

  ubes_remote ubes_remote_inst (.i_clk(clk_sys), .i_line(txd), .o_line(rxd));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(posedge clk_sys);
    d = rdata;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd_reg(a, v);
    chk8(v, e);
  endtask

  task automatic t_regs();
    rd_chk(`UBES_ADDR_ERR, 8'h00);
    rd_chk(`UBES_ADDR_BRG, 8'h00);
    rd_chk(`UBES_ADDR_STATE, 8'h00);
    wr_reg(`UBES_ADDR_ERR, 8'hff);
    rd_chk(`UBES_ADDR_ERR, 8'h00);
    wr_reg(`UBES_ADDR_BRG, 8'hff);
    rd_chk(`UBES_ADDR_BRG, 8'hf0);
    rd_chk(16'hff7f, 8'h00);
  endtask

  // Every parity code with a spoilt parity bit
  task automatic t_rx();
    logic [1:0] ps;
    wr_reg(`UBES_ADDR_BRG, 8'h10);
    for (int p = 0; p < 4; p++) begin
      ps = p[1:0];
      wr_reg(`UBES_ADDR_MODE, {2'b01, ps, 4'h8});
      ubes_remote_inst.send(8'ha5, 8, ps, 1'b1, 1'b0, 64);
      rd_chk(`UBES_ADDR_DATA, 8'ha5);
      rd_chk(`UBES_ADDR_ERR, {5'h00, ps[1], 2'b00});
    end
    rd_chk(`UBES_ADDR_STATE, 8'h04);
  endtask

  // Bad stop, then two-stop setting with frames one stop apart
  task automatic t_frame();
    logic [7:0] v;
    wr_reg(`UBES_ADDR_MODE, 8'h4c);
    ubes_remote_inst.send(8'h81, 8, 2'b00, 1'b0, 1'b1, 64);
    rd_chk(`UBES_ADDR_ERR, 8'h02);
    rd_reg(`UBES_ADDR_DATA, v);
    ubes_remote_inst.send(8'h7e, 8, 2'b00, 1'b0, 1'b0, 64);
    ubes_remote_inst.send(8'h18, 8, 2'b00, 1'b0, 1'b0, 64);
    rd_chk(`UBES_ADDR_ERR, 8'h01);
    rd_chk(`UBES_ADDR_DATA, 8'h18);
  endtask

  task automatic t_overrun();
    ubes_remote_inst.send(8'h11, 8, 2'b00, 1'b0, 1'b0, 64);
    ubes_remote_inst.send(8'h22, 8, 2'b00, 1'b0, 1'b0, 64);
    rd_chk(`UBES_ADDR_ERR, 8'h01);
    ubes_remote_inst.send(8'h33, 8, 2'b00, 1'b0, 1'b0, 64);
    rd_chk(`UBES_ADDR_ERR, 8'h01);
    rd_chk(`UBES_ADDR_DATA, 8'h33);
    ubes_remote_inst.send(8'h44, 8, 2'b00, 1'b0, 1'b0, 64);
    rd_chk(`UBES_ADDR_ERR, 8'h00);
    rd_chk(`UBES_ADDR_DATA, 8'h44);
  endtask

  // A pending framing flag must not show in clocked mode
  task automatic t_clocked();
    logic [7:0] v;
    int         tg;
    ubes_remote_inst.send(8'h0f, 8, 2'b00, 1'b0, 1'b1, 64);
    rd_reg(`UBES_ADDR_DATA, v);
    wr_reg(`UBES_ADDR_MODE, 8'h00);
    wr_reg(`UBES_ADDR_CSM, 8'h86);
    rd_chk(`UBES_ADDR_ERR, 8'h00);
    chk8({7'h00, sck_oe_n}, 8'h00);
    // Code 1 gives a shift period of 8 clocks: 8 level changes in 32 clocks
    tg = 0;
    repeat (32) begin
      v[0] = sck;
      @(posedge clk_sys);
      if (sck !== v[0]) tg++;
    end
    chk8(tg[7:0], 8'h08);
    wr_reg(`UBES_ADDR_CSM, 8'h84);
    rd_chk(`UBES_ADDR_ERR, 8'h00);
    chk8({7'h00, sck_oe_n}, 8'h01);
    wr_reg(`UBES_ADDR_CSM, 8'h00);
    rd_chk(`UBES_ADDR_STATE, 8'h00);
    wr_reg(`UBES_ADDR_MODE, 8'h40);
    rd_reg(`UBES_ADDR_ERR, v);
  endtask

  task automatic t_tx();
    logic [7:0] d;
    logic       p;
    wr_reg(`UBES_ADDR_BRG, 8'h20);
    wr_reg(`UBES_ADDR_MODE, 8'ha8);
    wr_reg(`UBES_ADDR_DATA, 8'h3c);
    ubes_remote_inst.recv(d, p, 8, 128);
    chk8(d, 8'h3c);
    chk8({7'h00, p}, 8'h01);
    chk8({7'h00, rxd_port}, 8'h01);
    // Let the stop bit finish before touching the baud control
    repeat (256) @(posedge clk_sys);
  endtask

  task automatic t_ext();
    wr_reg(`UBES_ADDR_BRG, 8'h80);
    // Seven-bit characters land in bits 6..0
    wr_reg(`UBES_ADDR_MODE, 8'h40);
    asck_run <= 1'b1;
    ubes_remote_inst.send(8'hc3, 7, 2'b00, 1'b0, 1'b0, 96);
    rd_chk(`UBES_ADDR_DATA, 8'h43);
    rd_chk(`UBES_ADDR_ERR, 8'h00);
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_rx();
    t_frame();
    t_overrun();
    t_clocked();
    t_tx();
    t_ext();
    report_and_stop();
  end

  // Roughly five times the expected run
  initial begin
    repeat (50000) @(posedge clk_sys);
    fail_count++;
    report_and_stop();
  end
endmodule // tb_top

`default_nettype wire
